/* File: shared/scc_pkg.sv */
// constants and types of the system clock source control block
// assumes a single 50 MHz clock and 8-bit registers
package scc_pkg;
    localparam int CLK_HZ           = 50_000_000;
    localparam int XTAL_MIN_HZ      = 32_000;
    localparam int XTAL_MAX_HZ      = 4_000_000;
    // least clock cycles between two crystal edges at the top frequency
    localparam int XTAL_MIN_GAP_CYC = CLK_HZ / XTAL_MAX_HZ;

    localparam int NUM_OSC  = 3;
    localparam int OSC_FAST = 0;
    localparam int OSC_SLOW = 1;
    localparam int OSC_XTAL = 2;

    localparam logic [7:0] OFS_CLK_MODE  = 8'h03;
    localparam logic [7:0] OFS_XTAL_CTRL = 8'h0a;
    localparam logic [7:0] OFS_STATUS    = 8'h0b;

    localparam int XTAL_EN_BIT   = 7;
    localparam int XTAL_DRV_HI   = 6;
    localparam int XTAL_DRV_LO   = 5;
    localparam int MODE_SEL_HI   = 7;
    localparam int MODE_SEL_LO   = 5;
    localparam int MODE_FAST_BIT = 4;
    localparam int MODE_DIV_BIT  = 3;
    localparam int MODE_SLOW_BIT = 2;

    localparam logic [7:0] XTAL_CTRL_RST   = 8'h00;
    localparam logic [7:0] MODE_SLOW_BOOT  = 8'he4;
    localparam logic [7:0] MODE_FAST_BOOT  = 8'h74;
    localparam logic [7:0] MODE_FAST_DIV2  = 8'h34;
    localparam logic [7:0] MODE_FAST_DIV4  = 8'h14;
    localparam logic [7:0] MODE_FAST_DIV8  = 8'h3c;
    localparam logic [7:0] MODE_FAST_DIV16 = 8'h1c;
    localparam logic [7:0] MODE_FAST_DIV32 = 8'h7c;
    localparam logic [7:0] MODE_SLOW_ONLY  = 8'he4;
    localparam logic [7:0] MODE_SLOW_KEEP  = 8'hf4;
    localparam logic [7:0] MODE_XTAL_KEEP  = 8'hb4;
    localparam logic [7:0] MODE_XTAL_ALT   = 8'hb0;

    typedef enum logic [1:0] {
        SRC_FAST = 2'b00,
        SRC_SLOW = 2'b01,
        SRC_XTAL = 2'b10
    } scc_src_t;

    typedef enum logic [2:0] {
        TRIM_OFF   = 3'd0,
        TRIM_DIV2  = 3'd1,
        TRIM_DIV4  = 3'd2,
        TRIM_DIV8  = 3'd3,
        TRIM_DIV16 = 3'd4,
        TRIM_DIV32 = 3'd5,
        TRIM_SLOW  = 3'd6
    } scc_trim_t;

    typedef enum logic [1:0] {
        BOOT_WAIT0 = 2'b00,
        BOOT_WAIT1 = 2'b01,
        BOOT_LOAD  = 2'b11,
        BOOT_RUN   = 2'b10
    } scc_boot_t;
endpackage : scc_pkg

/* File: shared/scc_osc_if.sv */
// oscillator ticks, enables and clock selection between the block's modules
// assumes all members change on clock_i of the block
interface scc_osc_if;
    import scc_pkg::*;
    logic [NUM_OSC-1:0] osc_en;
    logic [NUM_OSC-1:0] osc_tick;
    scc_src_t           src;
    logic [2:0]         div_log;
    logic               sys_tick;

    modport gate (input osc_en, output osc_tick);
    modport div  (input osc_tick, input src, input div_log, output sys_tick);
    modport ctrl (output osc_en, output src, output div_log,
                  input osc_tick, input sys_tick);
endinterface : scc_osc_if

/* File: rtl/scc_osc_gate.sv */
// synchronises the three oscillator pins and gates their edges by enable
// assumes pins are free-running and slower than half of clock_i
module scc_osc_gate (
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    input  wire logic [scc_pkg::NUM_OSC-1:0] osc_pin_i,
    scc_osc_if.gate                      osc
);
    import scc_pkg::*;

    for (genvar g = 0; g < NUM_OSC; g++) begin : g_osc
        logic meta_q, sync_q, last_q, tick_q;
        logic meta_d, sync_d, last_d, tick_d;

        // two flops at 50 MHz resolve every edge up to the 4 MHz crystal
        always_comb begin // RULE5
            meta_d = osc_pin_i[g];
            sync_d = meta_q;
            // history tracks the pin even while off, so enabling on a high pin
            // makes no false edge
            last_d = sync_q;
            tick_d = osc.osc_en[g] & sync_q & ~last_q; // RULE15
        end

        always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
                last_q <= 1'b0;
                tick_q <= 1'b0;
            end else begin
                meta_q <= meta_d;
                sync_q <= sync_d;
                last_q <= last_d;
                tick_q <= tick_d;
            end
        end

        assign osc.osc_tick[g] = tick_q;

        property p_gated_off;
            @(posedge clock_i) disable iff (!rst_n_i)
            !osc.osc_en[g] |=> !tick_q;
        endproperty
        a_gated_off: assert property (p_gated_off) // RULE15
            else $error("tick from a disabled oscillator");
    end
endmodule // scc_osc_gate

/* File: rtl/scc_clk_div.sv */
// picks the selected oscillator tick and divides it into system ticks
// assumes src and div_log come straight from the mode register decode
module scc_clk_div (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    scc_osc_if.div    osc
);
    import scc_pkg::*;

    logic [5:0] count_q, count_d;
    logic [5:0] lim;
    logic       tick_q, tick_d, pick;
    scc_src_t   src_q, src_d;
    logic [2:0] div_q, div_d;
    logic       changed;

    always_comb begin
        unique case (osc.src)
            SRC_FAST: pick = osc.osc_tick[OSC_FAST];
            SRC_XTAL: pick = osc.osc_tick[OSC_XTAL];
            default:  pick = osc.osc_tick[OSC_SLOW];
        endcase
        lim     = 6'((7'd1 << osc.div_log) - 7'd1);
        changed = (osc.src != src_q) || (osc.div_log != div_q);
        src_d   = osc.src;
        div_d   = osc.div_log;
        count_d = count_q;
        tick_d  = 1'b0;
        // a new setting restarts the divider at once
        if (changed) begin // RULE10
            count_d = 6'h00;
            tick_d  = pick && (lim == 6'h00);
        end else if (pick) begin
            if (count_q >= lim) begin
                count_d = 6'h00;
                tick_d  = 1'b1;
            end else begin
                count_d = count_q + 6'h01;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            count_q <= 6'h00;
            tick_q  <= 1'b0;
            src_q   <= SRC_SLOW;
            div_q   <= 3'h0;
        end else begin
            count_q <= count_d;
            tick_q  <= tick_d;
            src_q   <= src_d;
            div_q   <= div_d;
        end
    end

    assign osc.sys_tick = tick_q;

    property p_restart;
        @(posedge clock_i) disable iff (!rst_n_i)
        (osc.src != src_q) |=> (count_q == 6'h00);
    endproperty
    a_restart: assert property (p_restart) // RULE10
        else $error("divider not restarted on clock switch");
endmodule // scc_clk_div

/* File: rtl/scc_top.sv */
// system clock source control: boot setup, clock mode, crystal control
// assumes a simple register port and oscillator pins sampled at 50 MHz

// Behaviour
// [RULE1] trim /2 /4 /8 boots 0x34 0x14 0x3c
// [RULE2] trim /16 /32 slow boots 0x1c 0x7c 0xe4
// [RULE3] calibrated boot: no watchdog, slow on, input
// [RULE4] trim off: boot mode kept, watchdog, no bandgap
// [RULE5] crystal from 32 kHz to 4 MHz
// [RULE6] crystal control bit 7 switches crystal
// [RULE7] crystal bits 6:5 set drive strength
// [RULE8] software waits for crystal before selecting it
// [RULE9] software stops crystal before deep power-down
// [RULE10] mode write switches source and divider immediately
// [RULE11] never stop active oscillator while switching away; mode writes are not checked for this, they are taken as is
// [RULE12] 0xf4 selects slow rc, fast stays on
// [RULE13] 0xb4 0xb0 select crystal, fast stays on
// [RULE14] three oscillators enabled by separate bits
// [RULE15] disabled oscillator delivers no edges
module scc_top (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic [2:0] trim_option_i,
    input  wire logic       fast_boot_i,
    input  wire logic       fast_rc_pin_i,
    input  wire logic       slow_rc_pin_i,
    input  wire logic       crystal_pin_i,
    output logic            sys_clock_tick_o,
    output logic            fast_rc_enable_o,
    output logic            slow_rc_enable_o,
    output logic            crystal_enable_o,
    output logic      [1:0] crystal_drive_o,
    output logic            watchdog_enable_o,
    output logic            bandgap_enable_o,
    output logic            port_a_bit_five_input_o,
    output logic            boot_done_o
);
    import scc_pkg::*;

    scc_osc_if osc ();

    scc_boot_t  state_q, state_d;
    logic [2:0] trim_meta_q, trim_sync_q;
    logic       fboot_meta_q, fboot_sync_q;
    logic [7:0] mode_q, mode_d;
    logic [7:0] xtal_q, xtal_d;
    logic [7:0] rdata_q, rdata_d;
    logic       wdt_q, wdt_d;
    logic       bgap_q, bgap_d;
    logic       pin_in_q, pin_in_d;
    logic       done_q, done_d;
    logic       wr_mode, wr_xtal;
    logic [2:0] sel;
    logic [2:0] div_log;
    scc_src_t   src;

    // straps are caught only after release, two flops from the pins
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            trim_meta_q  <= 3'h0;
            trim_sync_q  <= 3'h0;
            fboot_meta_q <= 1'b0;
            fboot_sync_q <= 1'b0;
        end else begin
            trim_meta_q  <= trim_option_i;
            trim_sync_q  <= trim_meta_q;
            fboot_meta_q <= fast_boot_i;
            fboot_sync_q <= fboot_meta_q;
        end
    end

    scc_osc_gate u_gate (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .osc_pin_i ({crystal_pin_i, slow_rc_pin_i, fast_rc_pin_i}),
        .osc       (osc.gate)
    );

    scc_clk_div u_div (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .osc     (osc.div)
    );

    // register writes are ignored until the boot setup has landed
    assign wr_mode = wr_i && (addr_i == OFS_CLK_MODE) && (state_q == BOOT_RUN);
    assign wr_xtal = wr_i && (addr_i == OFS_XTAL_CTRL) && (state_q == BOOT_RUN);

    // boot sequence and register file
    always_comb begin
        state_d  = state_q;
        mode_d   = mode_q;
        xtal_d   = xtal_q;
        wdt_d    = wdt_q;
        bgap_d   = bgap_q;
        pin_in_d = pin_in_q;
        unique case (state_q)
            BOOT_WAIT0: state_d = BOOT_WAIT1;
            BOOT_WAIT1: state_d = BOOT_LOAD;
            BOOT_LOAD: begin
                state_d  = BOOT_RUN;
                pin_in_d = 1'b1; // RULE3
                wdt_d    = 1'b0; // RULE3
                bgap_d   = 1'b1;
                unique case (trim_sync_q)
                    TRIM_DIV2:  mode_d = MODE_FAST_DIV2;  // RULE1
                    TRIM_DIV4:  mode_d = MODE_FAST_DIV4;  // RULE1
                    TRIM_DIV8:  mode_d = MODE_FAST_DIV8;  // RULE1
                    TRIM_DIV16: mode_d = MODE_FAST_DIV16; // RULE2
                    TRIM_DIV32: mode_d = MODE_FAST_DIV32; // RULE2
                    TRIM_SLOW:  mode_d = MODE_SLOW_ONLY;  // RULE2
                    default: begin
                        // boot value stands, chosen by the boot-up speed strap
                        mode_d = fboot_sync_q ? MODE_FAST_BOOT : MODE_SLOW_BOOT; // RULE4
                        wdt_d  = 1'b1; // RULE4
                        bgap_d = 1'b0; // RULE4
                    end
                endcase
            end
            BOOT_RUN: begin
                // written as is: an unsafe switch is software's to avoid
                if (wr_mode) begin
                    mode_d = wdata_i; // RULE10
                end
                if (wr_xtal) begin
                    xtal_d = {wdata_i[7:5], 5'h00}; // RULE6 RULE7
                end
            end
        endcase
        // registered copy so the pin comes straight from a flop
        done_d = (state_d == BOOT_RUN);
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q  <= BOOT_WAIT0;
            mode_q   <= MODE_SLOW_BOOT;
            xtal_q   <= XTAL_CTRL_RST;
            wdt_q    <= 1'b1;
            bgap_q   <= 1'b0;
            pin_in_q <= 1'b1;
            done_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            mode_q   <= mode_d;
            xtal_q   <= xtal_d;
            wdt_q    <= wdt_d;
            bgap_q   <= bgap_d;
            pin_in_q <= pin_in_d;
            done_q   <= done_d;
        end
    end

    // mode decode: select field plus divide bit
    always_comb begin
        sel     = mode_q[MODE_SEL_HI:MODE_SEL_LO];
        src     = SRC_SLOW;
        div_log = 3'd0;
        unique case (sel)
            3'b000: begin
                src     = SRC_FAST;
                div_log = mode_q[MODE_DIV_BIT] ? 3'd4 : 3'd2;
            end
            3'b001: begin
                src     = SRC_FAST;
                div_log = mode_q[MODE_DIV_BIT] ? 3'd3 : 3'd1;
            end
            3'b011: begin
                src     = SRC_FAST;
                div_log = mode_q[MODE_DIV_BIT] ? 3'd5 : 3'd6;
            end
            3'b101:  src = SRC_XTAL; // RULE13
            default: src = SRC_SLOW; // RULE12
        endcase
    end

    assign osc.src     = src; // RULE10
    assign osc.div_log = div_log;
    // each oscillator hangs on its own bit only
    assign osc.osc_en[OSC_FAST] = mode_q[MODE_FAST_BIT]; // RULE14
    assign osc.osc_en[OSC_SLOW] = mode_q[MODE_SLOW_BIT]; // RULE14
    assign osc.osc_en[OSC_XTAL] = xtal_q[XTAL_EN_BIT];   // RULE6 RULE14

    // read data valid only in the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                OFS_CLK_MODE:  rdata_d = mode_q;
                OFS_XTAL_CTRL: rdata_d = xtal_q;
                OFS_STATUS:    rdata_d = {bgap_q, wdt_q, osc.osc_en, src,
                                          state_q == BOOT_RUN};
                default:       rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o                 = rdata_q;
    assign sys_clock_tick_o        = osc.sys_tick;
    assign fast_rc_enable_o        = mode_q[MODE_FAST_BIT];
    assign slow_rc_enable_o        = mode_q[MODE_SLOW_BIT];
    assign crystal_enable_o        = xtal_q[XTAL_EN_BIT];
    assign crystal_drive_o         = xtal_q[XTAL_DRV_HI:XTAL_DRV_LO]; // RULE7
    assign watchdog_enable_o       = wdt_q;
    assign bandgap_enable_o        = bgap_q;
    assign port_a_bit_five_input_o = pin_in_q;
    assign boot_done_o             = done_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_load(logic [2:0] t);
        state_q == BOOT_LOAD && trim_sync_q == t;
    endsequence
    sequence s_wr(logic [7:0] a);
        wr_i && addr_i == a && state_q == BOOT_RUN;
    endsequence

    property p_boot_div2;
        s_load(TRIM_DIV2) |=> mode_q == 8'h34 && fast_rc_enable_o ##1 boot_done_o;
    endproperty
    a_boot_div2: assert property (p_boot_div2) // RULE1
        else $error("trim /2 boot mode wrong");

    property p_boot_div8;
        s_load(TRIM_DIV8) |=> mode_q == 8'h3c && fast_rc_enable_o;
    endproperty
    a_boot_div8: assert property (p_boot_div8) // RULE1
        else $error("trim /8 boot mode wrong");

    property p_boot_slow;
        s_load(TRIM_SLOW) |=> mode_q == 8'he4 && !fast_rc_enable_o;
    endproperty
    a_boot_slow: assert property (p_boot_slow) // RULE2
        else $error("slow trim boot mode wrong");

    property p_boot_cal;
        state_q == BOOT_LOAD && trim_sync_q inside {[TRIM_DIV2:TRIM_SLOW]} |=>
            !watchdog_enable_o && slow_rc_enable_o && port_a_bit_five_input_o;
    endproperty
    a_boot_cal: assert property (p_boot_cal) // RULE3
        else $error("calibrated boot side effects wrong");

    property p_boot_off;
        s_load(TRIM_OFF) |=> watchdog_enable_o && !bandgap_enable_o &&
            (mode_q == MODE_SLOW_BOOT || mode_q == MODE_FAST_BOOT);
    endproperty
    a_boot_off: assert property (p_boot_off) // RULE4
        else $error("untrimmed boot state wrong");

    property p_xtal_en;
        s_wr(OFS_XTAL_CTRL) |=> crystal_enable_o == $past(wdata_i[7]);
    endproperty
    a_xtal_en: assert property (p_xtal_en) // RULE6
        else $error("crystal enable not following write");

    property p_xtal_drive;
        s_wr(OFS_XTAL_CTRL) |=> crystal_drive_o == $past(wdata_i[6:5]);
    endproperty
    a_xtal_drive: assert property (p_xtal_drive) // RULE7
        else $error("crystal drive not following write");

    property p_mode_now;
        s_wr(OFS_CLK_MODE) |=> mode_q == $past(wdata_i) ##1 $stable(mode_q) || $past(wr_mode);
    endproperty
    a_mode_now: assert property (p_mode_now) // RULE10
        else $error("mode write not applied at once");

    property p_keep_fast;
        s_wr(OFS_CLK_MODE) ##0 wdata_i == 8'hf4 |=> fast_rc_enable_o && osc.src == SRC_SLOW;
    endproperty
    a_keep_fast: assert property (p_keep_fast) // RULE12
        else $error("0xf4 did not keep fast rc on slow source");

    property p_xtal_sel;
        s_wr(OFS_CLK_MODE) ##0 (wdata_i == 8'hb4 || wdata_i == 8'hb0) |=>
            osc.src == SRC_XTAL && fast_rc_enable_o == $past(wdata_i[4]);
    endproperty
    a_xtal_sel: assert property (p_xtal_sel) // RULE13
        else $error("crystal selection wrong");

    property p_indep;
        s_wr(OFS_XTAL_CTRL) |=> $stable(mode_q);
    endproperty
    a_indep: assert property (p_indep) // RULE14
        else $error("crystal write disturbed clock mode");
endmodule // scc_top

/* File: sim/scc_osc_model.sv */
// oscillator model: fast rc, slow rc and crystal sources for the clock block
// assumes enables come from the block's registered enable outputs
module scc_osc_model #(
    parameter int FAST_HALF_NS = 60,
    parameter int SLOW_HALF_NS = 1000,
    parameter int XTAL_HALF_NS = 125
) (
    input  wire logic fast_en_i,
    input  wire logic slow_en_i,
    input  wire logic xtal_en_i,
    output logic      fast_pin_o,
    output logic      slow_pin_o,
    output logic      xtal_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // a stopped oscillator parks low, no stray edges reach the block
    always begin
        if (fast_en_i === 1'b1) #(FAST_HALF_NS) fast_pin_o = ~fast_pin_o;
        else begin
            fast_pin_o = 1'b0;
            @(fast_en_i);
        end
    end

    always begin
        if (slow_en_i === 1'b1) #(SLOW_HALF_NS) slow_pin_o = ~slow_pin_o;
        else begin
            slow_pin_o = 1'b0;
            @(slow_en_i);
        end
    end

    // crystal starts at once; software still waits before using it
    always begin
        if (xtal_en_i === 1'b1) #(XTAL_HALF_NS) xtal_pin_o = ~xtal_pin_o;
        else begin
            xtal_pin_o = 1'b0;
            @(xtal_en_i);
        end
    end
endmodule // scc_osc_model

/* File: sim/testbench.sv */
// self-checking bench for the system clock source control block
// assumes scc_top, scc_pkg and the oscillator model are compiled before it
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import scc_pkg::*;
    localparam int WIN = 1200;
    localparam int FH  = 60;
    localparam int SH  = 1000;
    localparam int XH  = 125;
    logic       clock_i, rst_n_i, wr, rd, fast_boot, tick, boot_done;
    logic       fast_pin, slow_pin, xtal_pin, fast_en, slow_en, xtal_en;
    logic       wdog, bgap, port_in, fb, off;
    logic [7:0] addr, wdata, rdata_o, v, m, w;
    logic [2:0] trim;
    logic [1:0] drive;
    int         n_fail, tests_run;

    scc_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .trim_option_i(trim),
        .fast_boot_i(fast_boot), .fast_rc_pin_i(fast_pin), .slow_rc_pin_i(slow_pin),
        .crystal_pin_i(xtal_pin), .sys_clock_tick_o(tick), .fast_rc_enable_o(fast_en),
        .slow_rc_enable_o(slow_en), .crystal_enable_o(xtal_en), .crystal_drive_o(drive),
        .watchdog_enable_o(wdog), .bandgap_enable_o(bgap),
        .port_a_bit_five_input_o(port_in), .boot_done_o(boot_done));

    scc_osc_model #(.FAST_HALF_NS(FH), .SLOW_HALF_NS(SH), .XTAL_HALF_NS(XH)) osc (
        .fast_en_i(fast_en), .slow_en_i(slow_en), .xtal_en_i(xtal_en),
        .fast_pin_o(fast_pin), .slow_pin_o(slow_pin), .xtal_pin_o(xtal_pin));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check8(string name, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic check1(string name, logic e, logic g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic bus_write(logic [7:0] a, logic [7:0] d);
        @(posedge clock_i);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock_i);
        wr    <= 1'b0;
    endtask

    task automatic bus_read(logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clock_i);
        rd   <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic do_reset(logic [2:0] t, logic b);
        @(posedge clock_i);
        rst_n_i   <= 1'b0;
        trim      <= t;
        fast_boot <= b;
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 20 && boot_done !== 1'b1; i++) @(posedge clock_i) #1;
        check1("boot done", 1'b1, boot_done);
        if (boot_done !== 1'b1) tally_and_finish();
    endtask

    function automatic logic [7:0] boot_mode(logic [2:0] t, logic b);
        case (t)
            3'd1:    return 8'h34;
            3'd2:    return 8'h14;
            3'd3:    return 8'h3c;
            3'd4:    return 8'h1c;
            3'd5:    return 8'h7c;
            3'd6:    return 8'he4;
            default: return b ? 8'h74 : 8'he4;
        endcase
    endfunction

    function automatic int boot_div(logic [2:0] t, logic b);
        case (t)
            3'd1:    return 2;
            3'd2:    return 4;
            3'd3:    return 8;
            3'd4:    return 16;
            3'd5:    return 32;
            3'd6:    return 1;
            default: return b ? 64 : 1;
        endcase
    endfunction

    // ticks expected in the window for a source half period and divider
    function automatic int exp_ticks(int half_ns, int div);
        return WIN * 20 / (2 * half_ns * div);
    endfunction

    // rate check rather than exact edges: sync delay shifts the window edges
    task automatic check_rate(string name, int half_ns, int div);
        int n;
        int e;
        n = 0;
        e = exp_ticks(half_ns, div);
        repeat (WIN) begin
            @(posedge clock_i) #1;
            if (tick === 1'b1) n++;
        end
        tests_run++;
        if (n < e - 3 || n > e + 3) begin
            n_fail++;
            $display("Error %s expected %0d seen %0d", name, e, n);
        end
    endtask

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    initial begin
        rst_n_i = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
        trim = '0; fast_boot = 1'b0; n_fail = 0; tests_run = 0;
        void'($urandom(15652));
        for (int t = 0; t < 8; t++) begin
            // both untrimmed boot speeds are forced once, the rest is random
            fb  = (t == 0) ? 1'b1 : (t == 7) ? 1'b0 : 1'($urandom_range(1, 0));
            off = (t == 0 || t == 7);
            do_reset(3'(t), fb);
            m = boot_mode(3'(t), fb);
            bus_read(OFS_CLK_MODE, v);
            check8("boot mode", m, v);
            check1("fast enable", m[4], fast_en);
            check1("slow enable", m[2], slow_en);
            check1("port input", 1'b1, port_in);
            check1("watchdog", off, wdog);
            if (off) begin
                check1("bandgap", 1'b0, bgap);
                bus_read(OFS_STATUS, v);
                check8("status", {2'b01, 1'b0, m[2], m[4], 1'b0, m[7], 1'b1}, v);
            end
            check_rate("boot ticks", m[7] ? SH : FH, boot_div(3'(t), fb));
            $display("test boot option %0d done", t);
        end

        do_reset(3'd1, 1'b0);
        check_rate("div2 ticks", FH, 2);
        for (int d = 1; d < 4; d++) begin
            w = {1'b1, 2'(d), 5'($urandom)};
            bus_write(OFS_XTAL_CTRL, w);
            bus_read(OFS_XTAL_CTRL, v);
            check8("crystal ctrl", w & 8'he0, v);
            check1("crystal enable", 1'b1, xtal_en);
            check8("drive", {6'h00, 2'(d)}, {6'h00, drive});
        end
        bus_write(OFS_XTAL_CTRL, {3'b011, 5'($urandom)});
        bus_write(8'h55, 8'hff);
        bus_read(8'h55, v);
        check8("unmapped", 8'h00, v);
        check1("crystal enable", 1'b0, xtal_en);
        bus_read(OFS_CLK_MODE, v);
        check8("mode kept", 8'h34, v);
        $display("test registers done");

        bus_write(OFS_CLK_MODE, 8'hf4);
        check_rate("slow ticks", SH, 1);
        check1("fast kept", 1'b1, fast_en);
        bus_write(OFS_CLK_MODE, 8'he4);
        repeat (2) @(posedge clock_i) #1;
        check1("fast off", 1'b0, fast_en);
        check_rate("slow alone", SH, 1);
        bus_write(OFS_XTAL_CTRL, 8'he0);
        repeat (200) @(posedge clock_i);
        bus_write(OFS_CLK_MODE, 8'hb4);
        check_rate("crystal ticks", XH, 1);
        check1("fast on", 1'b1, fast_en);
        bus_write(OFS_CLK_MODE, 8'hb0);
        check_rate("crystal alt", XH, 1);
        check1("slow off", 1'b0, slow_en);
        check1("fast stays", 1'b1, fast_en);
        bus_write(OFS_CLK_MODE, 8'h14);
        check_rate("div4 ticks", FH, 4);
        bus_write(OFS_XTAL_CTRL, 8'h00);
        check_rate("div4 after", FH, 4);
        check1("crystal off", 1'b0, xtal_en);
        $display("test switching done");
        tally_and_finish();
    end
endmodule // testbench
